// File: core/lcp_link_if.sv
// word-serial login payload link between port and responder
`timescale 1ns/1ps
`default_nettype none
interface lcp_link_if;
    logic        rqValid;
    logic        rqReady;
    logic [31:0] rqData;
    logic        rqIsPlogi;
    logic        acValid;
    logic        acReady;
    logic [31:0] acData;

    modport port (output rqValid, input rqReady, output rqData, output rqIsPlogi,
                  input acValid, output acReady, input acData);
    modport peer (input rqValid, output rqReady, input rqData, input rqIsPlogi,
                  output acValid, input acReady, output acData);
endinterface
`default_nettype wire

// File: core/lcp_pkg.sv
// shared constants and types for the login common parameter codec
package lcp_pkg;
    localparam int          LCP_WORDS      = 4;
    localparam logic [1:0]  LCP_LAST_WORD  = 2'h3;
    localparam logic [15:0] LCP_CREDIT_MAX = 16'h7fff;
    localparam logic [15:0] LCP_CREDIT_DEF = 16'h0001;
    localparam logic [15:0] LCP_CREDIT_LP  = 16'h0000;
    localparam logic [7:0]  LCP_W2_TOP     = 8'h00;
    localparam logic [15:0] LCP_OBSOLETE   = 16'h0000;
    localparam int          LCP_BIT_HI     = 31;
    localparam int          LCP_BIT_LO     = 30;
    // register byte offsets
    localparam logic [5:0]  LCP_REG_CTRL   = 6'h00;
    localparam logic [5:0]  LCP_REG_CREDIT = 6'h04;
    localparam logic [5:0]  LCP_REG_FEAT   = 6'h08;
    localparam logic [5:0]  LCP_REG_W2     = 6'h0c;
    localparam logic [5:0]  LCP_REG_STAT   = 6'h10;
    localparam logic [5:0]  LCP_REG_PEERW1 = 6'h14;
    localparam logic [5:0]  LCP_REG_PEERW2 = 6'h18;
    localparam logic [5:0]  LCP_REG_PEERW3 = 6'h1c;
    // control bits
    localparam int          LCP_CTL_START  = 0;
    localparam int          LCP_CTL_PLOGI  = 1;
    localparam int          LCP_CTL_LOOP   = 2;
    localparam int          LCP_CTL_P2P    = 3;
    localparam int          LCP_CTL_SAME   = 4;
    // status bits, bits 1..3 cleared by writing one
    localparam int          LCP_ST_BUSY    = 0;
    localparam int          LCP_ST_DONE    = 1;
    localparam int          LCP_ST_PERR    = 2;
    localparam int          LCP_ST_TERR    = 3;
    localparam int          LCP_ST_CLEAN   = 4;
    localparam int          LCP_ST_VF      = 5;
    localparam int          LCP_ST_USED    = 6;
    localparam logic [31:0] LCP_RST_CREDIT = 32'h0000_0001;
    localparam logic [31:0] LCP_RST_FEAT   = 32'h0001_0000;
    localparam logic [31:0] LCP_RST_W2     = 32'h0001_0000;

    typedef enum logic [1:0] {
        LCP_IDLE = 2'b00,
        LCP_SEND = 2'b01,
        LCP_RECV = 2'b11
    } lcp_state_t;

    function automatic logic lcp_credit_ok(input logic [15:0] c);
        return (c != 16'h0000) && (c <= LCP_CREDIT_MAX);
    endfunction

    function automatic logic [15:0] lcp_credit_clamp(input logic [15:0] c);
        if (c == 16'h0000)
            return LCP_CREDIT_DEF;
        else if (c > LCP_CREDIT_MAX)
            return LCP_CREDIT_MAX;
        else
            return c;
    endfunction
endpackage

// File: core/lcp_port.sv
// port end: builds a login request, parses the accept, keeps the credit count
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - word 0 low half carries buffer credit
// RULE2 - sent credit is 1 to 32767, never 0
// RULE3 - one shared credit count for all frames
// RULE4 - port login credit only point-to-point or same loop
// RULE5 - continuous offset flag offered in port login
// RULE6 - offset flags apply only to masked categories
// RULE7 - offset capability holds as initiator and recipient
// RULE8 - clean address set only when address unused
// RULE9 - fabric request bit 31 shows multiple IDs
// RULE10 - random offset flag offered in port login
// RULE11 - fabric login bit 30 shows virtual fabrics
// RULE12 - port login word 2 layout zero, sequences, mask
// RULE13 - fabric accept carries timeouts in words 2, 3
// RULE14 - word 1 features, exponent, receive size
// RULE15 - obsolete version half is ignored
// RULE16 - default credit 1, loop port 0
// RULE17 - zero received credit flagged, not loaded
module lcp_port
    import lcp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    lcp_link_if.port         link,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        frameSent,
    input  wire logic        readyReturned,
    output logic             creditAvail,
    output logic [15:0]      roContMask,
    output logic [15:0]      roRandMask
);
    lcp_state_t  state_reg;
    logic [1:0]  idx_reg;
    logic [4:0]  ctrl_reg;
    logic [31:0] credit_reg;
    logic [31:0] feat_reg;
    logic [31:0] w2_reg;
    logic [3:0]  stat_reg;
    logic        clean_reg;
    logic        vf_reg;
    logic        used_reg;
    logic        loggedIn_reg;
    logic [15:0] creditCnt_reg;
    logic [15:0] creditCnt_next;
    logic [15:0] peerCredit_reg;
    logic [31:0] peerW1_reg;
    logic [31:0] peerW2_reg;
    logic [31:0] peerW3_reg;
    logic        rdDone_reg;
    logic [31:0] txWord;
    logic [31:0] rdMux;

    // feature register: 0 cont offset, 1 random offset, 2 multi id, 3 vf, 7:4 exponent, 27:16 rx size
    wire        isPlogi   = ctrl_reg[LCP_CTL_PLOGI];
    wire [15:0] myCredit  = credit_reg[15:0];
    wire        wrEn      = ce && avs_write;
    wire        rdEn      = ce && avs_read;
    wire        startReq  = wrEn && (avs_address == LCP_REG_CTRL) && avs_writedata[LCP_CTL_START];
    wire        creditBad = !lcp_credit_ok(myCredit);
    wire        launch    = startReq && (state_reg == LCP_IDLE) && !creditBad;   // [RULE2]
    wire        txFire    = ce && (state_reg == LCP_SEND) && link.rqReady;
    wire        rxFire    = ce && (state_reg == LCP_RECV) && link.acValid;
    wire        rxLast    = rxFire && (idx_reg == LCP_LAST_WORD);
    wire        stClr     = wrEn && (avs_address == LCP_REG_STAT);
    wire        creditUse = !isPlogi || ctrl_reg[LCP_CTL_P2P] || ctrl_reg[LCP_CTL_SAME]; // [RULE4]
    wire        peerZero  = (peerCredit_reg == 16'h0000);
    wire        loadCred  = rxLast && creditUse && !peerZero;                 // [RULE17]
    wire [15:0] featHi    = isPlogi ? {feat_reg[0], feat_reg[1], 14'h0000}    // [RULE5] [RULE10]
                                    : {feat_reg[2], feat_reg[3], 14'h0000};   // [RULE9] [RULE11]
    wire [15:0] defCredit = ctrl_reg[LCP_CTL_LOOP] ? LCP_CREDIT_LP : LCP_CREDIT_DEF; // [RULE16]
    // a send and a return together cancel, even at a saturated end
    wire        incCred   = readyReturned && !frameSent && (creditCnt_reg != LCP_CREDIT_MAX);
    wire        decCred   = frameSent && !readyReturned && (creditCnt_reg != 16'h0000);
    wire [3:0]  stSet     = {launch ? 1'b0 : startReq, rxLast && peerZero && creditUse,
                             rxLast, 1'b0};

    // the offset flags are advertised only for categories set in our own mask
    assign roContMask  = feat_reg[0] ? w2_reg[15:0] : 16'h0000;  // [RULE6] [RULE7]
    assign roRandMask  = feat_reg[1] ? w2_reg[15:0] : 16'h0000;  // [RULE6] [RULE7]
    assign creditAvail = (creditCnt_reg != 16'h0000);
    assign link.rqValid   = ce && (state_reg == LCP_SEND);
    assign link.rqData    = txWord;
    assign link.rqIsPlogi = isPlogi;
    assign link.acReady   = ce && (state_reg == LCP_RECV);
    // reads take one wait cycle so readdata comes from a flip-flop
    assign avs_waitrequest = !ce || (avs_read && !rdDone_reg);

    always_comb begin
        case (idx_reg)
            2'h0: txWord = {LCP_OBSOLETE, myCredit};                                 // [RULE1] [RULE15]
            2'h1: txWord = {featHi, feat_reg[7:4], feat_reg[27:16]};                 // [RULE14]
            2'h2: txWord = isPlogi ? {LCP_W2_TOP, w2_reg[23:16], w2_reg[15:0]}      // [RULE12]
                                   : 32'h0000_0000;
            default: txWord = 32'h0000_0000;
        endcase
    end

    always_comb begin
        case (avs_address)
            LCP_REG_CTRL:   rdMux = {27'h0, ctrl_reg[4:1], 1'b0};
            LCP_REG_CREDIT: rdMux = credit_reg;
            LCP_REG_FEAT:   rdMux = feat_reg;
            LCP_REG_W2:     rdMux = w2_reg;
            LCP_REG_STAT:   rdMux = {creditCnt_reg, 9'h0, used_reg, vf_reg, clean_reg,
                                     stat_reg[3:1], state_reg != LCP_IDLE};
            LCP_REG_PEERW1: rdMux = peerW1_reg;
            LCP_REG_PEERW2: rdMux = peerW2_reg;
            LCP_REG_PEERW3: rdMux = peerW3_reg;
            default:        rdMux = 32'h0000_0000;
        endcase
    end

    // single counter for every flow-controlled frame, whatever its class
    always_comb begin
        if (loadCred)
            creditCnt_next = peerCredit_reg;                     // [RULE4]
        else if (!loggedIn_reg)
            creditCnt_next = defCredit;                          // [RULE16]
        else if (incCred && !decCred)
            creditCnt_next = creditCnt_reg + 16'h0001;           // [RULE3]
        else if (decCred && !incCred)
            creditCnt_next = creditCnt_reg - 16'h0001;           // [RULE3]
        else
            creditCnt_next = creditCnt_reg;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg   <= 5'h00;
            credit_reg <= LCP_RST_CREDIT;
            feat_reg   <= LCP_RST_FEAT;
            w2_reg     <= LCP_RST_W2;
        end else if (wrEn) begin
            if (avs_address == LCP_REG_CTRL && state_reg == LCP_IDLE)
                ctrl_reg <= {avs_writedata[4:1], 1'b0};
            if (avs_address == LCP_REG_CREDIT)
                credit_reg <= {16'h0000, avs_writedata[15:0]};
            if (avs_address == LCP_REG_FEAT)
                feat_reg <= {4'h0, avs_writedata[27:16], 8'h00, avs_writedata[7:0]};
            if (avs_address == LCP_REG_W2)
                w2_reg <= {8'h00, avs_writedata[23:0]};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0000_0000;
            rdDone_reg   <= 1'b0;
        end else if (ce) begin
            rdDone_reg <= rdEn && !rdDone_reg;
            if (rdEn && !rdDone_reg)
                avs_readdata <= rdMux;
        end
    end

    // sticky status: a hardware set in the same cycle beats the software clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            stat_reg <= 4'h0;
        else if (ce)
            stat_reg <= stSet | (stat_reg & ~(stClr ? avs_writedata[3:0] : 4'h0));
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg      <= LCP_IDLE;
            idx_reg        <= 2'h0;
            peerCredit_reg <= 16'h0000;
            peerW1_reg     <= 32'h0000_0000;
            peerW2_reg     <= 32'h0000_0000;
            peerW3_reg     <= 32'h0000_0000;
        end else if (ce) begin
            case (state_reg)
                LCP_IDLE: begin
                    if (launch) begin
                        state_reg <= LCP_SEND;
                        idx_reg   <= 2'h0;
                    end
                end
                LCP_SEND: begin
                    if (txFire) begin
                        idx_reg <= idx_reg + 2'h1;
                        if (idx_reg == LCP_LAST_WORD)
                            state_reg <= LCP_RECV;
                    end
                end
                LCP_RECV: begin
                    if (rxFire) begin
                        idx_reg <= idx_reg + 2'h1;
                        case (idx_reg)
                            2'h0: peerCredit_reg <= link.acData[15:0];   // [RULE15]
                            2'h1: peerW1_reg     <= link.acData;
                            2'h2: peerW2_reg     <= link.acData;
                            default: peerW3_reg  <= link.acData;
                        endcase
                        if (rxLast)
                            state_reg <= LCP_IDLE;
                    end
                end
                default: state_reg <= LCP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            creditCnt_reg <= LCP_CREDIT_DEF;
            loggedIn_reg  <= 1'b0;
            clean_reg     <= 1'b0;
            vf_reg        <= 1'b0;
            used_reg      <= 1'b0;
        end else if (ce) begin
            creditCnt_reg <= creditCnt_next;
            if (launch)
                loggedIn_reg <= 1'b0;
            else if (loadCred)
                loggedIn_reg <= 1'b1;
            if (rxLast) begin
                // clean address and vf only mean something in a fabric accept
                clean_reg <= !isPlogi && peerW1_reg[LCP_BIT_HI];   // [RULE8]
                vf_reg    <= !isPlogi && peerW1_reg[LCP_BIT_LO];   // [RULE11]
                used_reg  <= loadCred;
            end
        end
    end
endmodule // lcp_port
`default_nettype wire

// File: core/lcp_responder.sv
// fabric or peer end: parses a login request and returns its accept
`timescale 1ns/1ps
`default_nettype none
module lcp_responder
    import lcp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    lcp_link_if.peer         link,
    input  wire logic [15:0] cfgCredit,
    input  wire logic        cfgAddrClean,
    input  wire logic        cfgVf,
    input  wire logic        cfgContOffset,
    input  wire logic        cfgRandOffset,
    input  wire logic [3:0]  cfgScN,
    input  wire logic [11:0] cfgRxSize,
    input  wire logic [7:0]  cfgConcSeq,
    input  wire logic [15:0] cfgRoMask,
    input  wire logic [31:0] cfgRaTov,
    input  wire logic [31:0] cfgEdTov,
    output logic             reqSeen,
    output logic             reqWasPlogi,
    output logic [15:0]      reqCredit,
    output logic             reqMultiId,
    output logic             reqVf
);
    lcp_state_t  state_reg;
    logic [1:0]  idx_reg;
    logic        plogi_reg;
    logic [31:0] word [LCP_WORDS];

    wire rqFire = ce && (state_reg == LCP_RECV) && link.rqValid;
    wire acFire = ce && (state_reg == LCP_SEND) && link.acReady;
    wire [15:0] featHi = plogi_reg ? {cfgContOffset, cfgRandOffset, 14'h0000}
                                   : {cfgAddrClean, cfgVf, 14'h0000}; // [RULE8] [RULE11]
    wire [31:0] word1 = {featHi, cfgScN, cfgRxSize};                    // [RULE14]

    assign link.rqReady = ce && (state_reg == LCP_RECV);
    assign link.acValid = ce && (state_reg == LCP_SEND);
    assign link.acData  = word[idx_reg];

    always_comb begin
        word[0] = {LCP_OBSOLETE, lcp_credit_clamp(cfgCredit)};          // [RULE1] [RULE2] [RULE13]
        word[1] = word1;
        word[2] = plogi_reg ? {LCP_W2_TOP, cfgConcSeq, cfgRoMask} : cfgRaTov; // [RULE12] [RULE13]
        word[3] = cfgEdTov;                                             // [RULE13]
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg   <= LCP_RECV;
            idx_reg     <= 2'h0;
            plogi_reg   <= 1'b0;
            reqSeen     <= 1'b0;
            reqWasPlogi <= 1'b0;
            reqCredit   <= 16'h0000;
            reqMultiId  <= 1'b0;
            reqVf       <= 1'b0;
        end else if (ce) begin
            reqSeen <= 1'b0;
            case (state_reg)
                LCP_RECV: begin
                    if (rqFire) begin
                        idx_reg <= idx_reg + 2'h1;
                        // obsolete version half of word 0 is never looked at
                        if (idx_reg == 2'h0) begin
                            plogi_reg <= link.rqIsPlogi;
                            reqCredit <= link.rqData[15:0];             // [RULE15]
                        end
                        if (idx_reg == 2'h1) begin
                            reqMultiId <= !plogi_reg && link.rqData[LCP_BIT_HI];
                            reqVf      <= !plogi_reg && link.rqData[LCP_BIT_LO]; // [RULE11]
                        end
                        if (idx_reg == LCP_LAST_WORD) begin
                            state_reg   <= LCP_SEND;
                            reqSeen     <= 1'b1;
                            reqWasPlogi <= plogi_reg;
                        end
                    end
                end
                LCP_SEND: begin
                    if (acFire) begin
                        idx_reg <= idx_reg + 2'h1;
                        if (idx_reg == LCP_LAST_WORD)
                            state_reg <= LCP_RECV;
                    end
                end
                default: begin
                    state_reg <= LCP_RECV;
                    idx_reg   <= 2'h0;
                end
            endcase
        end
    end
endmodule // lcp_responder
`default_nettype wire

// File: testbench/lcp_asserts.sv
// concurrent checks on the login payload link between the two ends
`timescale 1ns/1ps
`default_nettype none
module lcp_asserts
    import lcp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic        rqValid,
    input  wire logic        rqReady,
    input  wire logic [31:0] rqData,
    input  wire logic        rqIsPlogi,
    input  wire logic        acValid,
    input  wire logic        acReady,
    input  wire logic [31:0] acData
);
    logic [1:0] rqIdx_reg;
    logic [1:0] acIdx_reg;
    wire  logic rqTake = rqValid & rqReady & ce;
    wire  logic acTake = acValid & acReady & ce;

    // word index of each direction; payload is always four words, so wrap is the frame end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rqIdx_reg <= 2'h0;
            acIdx_reg <= 2'h0;
        end else begin
            rqIdx_reg <= rqIdx_reg + {1'b0, rqTake};
            acIdx_reg <= acIdx_reg + {1'b0, acTake};
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_rq_credit;
        rqTake && rqIdx_reg == 2'h0 |-> rqData[15:0] != 16'h0000 && rqData[15:0] <= LCP_CREDIT_MAX;
    endproperty
    a_rq_credit: assert property (p_rq_credit) else $error("request credit out of range");
    property p_ac_credit;
        acTake && acIdx_reg == 2'h0 |-> acData[15:0] != 16'h0000 && acData[15:0] <= LCP_CREDIT_MAX;
    endproperty
    a_ac_credit: assert property (p_ac_credit) else $error("accept credit out of range");
    property p_rq_obs;
        rqTake && rqIdx_reg == 2'h0 |-> rqData[31:16] == LCP_OBSOLETE;
    endproperty
    a_rq_obs: assert property (p_rq_obs) else $error("request version half not cleared");
    property p_ac_obs;
        acTake && acIdx_reg == 2'h0 |-> acData[31:16] == LCP_OBSOLETE;
    endproperty
    a_ac_obs: assert property (p_ac_obs) else $error("accept version half not cleared");
    property p_rq_w2;
        rqTake && rqIdx_reg == 2'h2 && rqIsPlogi |-> rqData[31:24] == LCP_W2_TOP;
    endproperty
    a_rq_w2: assert property (p_rq_w2) else $error("request word 2 top byte not zero");
    property p_ac_w2;
        acTake && acIdx_reg == 2'h2 && rqIsPlogi |-> acData[31:24] == LCP_W2_TOP;
    endproperty
    a_ac_w2: assert property (p_ac_w2) else $error("accept word 2 top byte not zero");
    // a payload is exactly four accept words, then the link goes quiet
    property p_end;
        acTake && acIdx_reg == 2'h3 |=> !acValid && !rqValid;
    endproperty
    a_end: assert property (p_end) else $error("accept ran past its last word");
    property p_turn;
        rqTake && rqIdx_reg == 2'h3 |=> !ce || (acValid && !rqValid);
    endproperty
    a_turn: assert property (p_turn) else $error("accept not started after last word");
endmodule // lcp_asserts
`default_nettype wire

// File: testbench/lcp_tb_top.sv
// self-checking bench: port end and responder end joined back to back
`timescale 1ns/1ps
`default_nettype none
module lcp_tb_top
    import lcp_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset_n, ce, avs_read, avs_write, avs_waitrequest;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, cfgRaTov, cfgEdTov;
    logic        frameSent, readyReturned, creditAvail, cfgAddrClean, cfgVf, cfgContOffset, cfgRandOffset;
    logic [15:0] roContMask, roRandMask, cfgCredit, cfgRoMask, reqCredit;
    logic [3:0]  cfgScN;
    logic [11:0] cfgRxSize;
    logic [7:0]  cfgConcSeq;
    logic        reqSeen, reqWasPlogi, reqMultiId, reqVf;
    int          errTotal, totalChecks;
    int          seenCnt = 0;

    lcp_link_if link();
    lcp_port lcp_port_inst (.clk(clk), .reset_n(reset_n), .ce(ce), .link(link), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .frameSent(frameSent), .readyReturned(readyReturned),
        .creditAvail(creditAvail), .roContMask(roContMask), .roRandMask(roRandMask));
    lcp_responder lcp_responder_inst (.clk(clk), .reset_n(reset_n), .ce(ce), .link(link), .cfgCredit(cfgCredit),
        .cfgAddrClean(cfgAddrClean), .cfgVf(cfgVf), .cfgContOffset(cfgContOffset), .cfgRandOffset(cfgRandOffset),
        .cfgScN(cfgScN), .cfgRxSize(cfgRxSize), .cfgConcSeq(cfgConcSeq), .cfgRoMask(cfgRoMask), .cfgRaTov(cfgRaTov),
        .cfgEdTov(cfgEdTov), .reqSeen(reqSeen), .reqWasPlogi(reqWasPlogi), .reqCredit(reqCredit),
        .reqMultiId(reqMultiId), .reqVf(reqVf));
    lcp_asserts lcp_asserts_inst (.clk(clk), .reset_n(reset_n), .ce(ce), .rqValid(link.rqValid),
        .rqReady(link.rqReady), .rqData(link.rqData), .rqIsPlogi(link.rqIsPlogi), .acValid(link.acValid),
        .acReady(link.acReady), .acData(link.acData));

    always #25 clk = ~clk;

    // reqSeen stands one cycle only, so count it rather than poll it
    always @(posedge clk) begin
        if (reqSeen === 1'b1)
            seenCnt <= seenCnt + 1;
    end

    task automatic stopTest();
        $display("checks %0d mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // request held until waitrequest is seen low at an edge; data taken at that edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 100) begin
                chk(32'h0, 32'h1, "bus timeout");
                stopTest();
            end
            @(posedge clk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    task automatic login(input logic [31:0] ctl);
        logic [31:0] q;
        int s0;
        q = 32'h0;
        s0 = seenCnt;
        wr(LCP_REG_CTRL, ctl | 32'h1);
        for (int n = 0; n < 40 && q[LCP_ST_DONE] !== 1'b1; n++) rd(LCP_REG_STAT, q);
        if (q[LCP_ST_DONE] !== 1'b1) begin
            chk(32'h0, 32'h1, "login timeout");
            stopTest();
        end
        chk(32'(seenCnt - s0), 32'h1, "one request per login");
        wr(LCP_REG_STAT, 32'h2);
    endtask

    task automatic pulse(input logic s, input logic r);
        @(posedge clk);
        frameSent <= s;
        readyReturned <= r;
        @(posedge clk);
        frameSent <= 1'b0;
        readyReturned <= 1'b0;
    endtask

    task automatic t_reset();
        logic [31:0] q;
        rd(LCP_REG_CREDIT, q);
        chk(q, LCP_RST_CREDIT, "credit reg reset");
        rd(LCP_REG_FEAT, q);
        chk(q, LCP_RST_FEAT, "feature reg reset");
        rd(LCP_REG_W2, q);
        chk(q, LCP_RST_W2, "word 2 reg reset");
        rd(LCP_REG_STAT, q);
        chk(q, 32'h0001_0000, "status reset, count one");
        rd(6'h3c, q);
        chk(q, 32'h0, "unmapped read");
        wr(LCP_REG_CTRL, 32'h4);
        rd(LCP_REG_STAT, q);
        chk({16'h0, q[31:16]}, 32'h0, "loop port default count");
        chk(32'(creditAvail), 32'h0, "loop port no credit");
        @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        chk(32'(avs_waitrequest), 32'h1, "stall while disabled");
        ce <= 1'b1;
    endtask

    // f selects both feature values; credit counting rides on the first pass
    task automatic t_flogi(input logic f);
        logic [31:0] q;
        @(posedge clk);
        cfgCredit <= 16'h0005;
        cfgAddrClean <= f;
        cfgVf <= f;
        wr(LCP_REG_FEAT, f ? 32'h0001_000c : 32'h0001_0000);
        login(32'h0);
        chk({29'h0, reqWasPlogi, reqMultiId, reqVf}, {30'h0, f, f}, "fabric request flags");
        chk({16'h0, reqCredit}, 32'h1, "request credit");
        rd(LCP_REG_STAT, q);
        chk(q, 32'h0005_0040 | (f ? 32'h30 : 32'h0), "fabric status");
        rd(LCP_REG_PEERW1, q);
        chk(32'({q[31:30], q[15:0]}), {14'h0, f, f, 16'h3800}, "accept word 1");
        rd(LCP_REG_PEERW2, q);
        chk(q, cfgRaTov, "accept word 2");
        rd(LCP_REG_PEERW3, q);
        chk(q, cfgEdTov, "accept word 3");
        if (f) begin
            repeat (6) pulse(1'b1, 1'b0);
            chk(32'(creditAvail), 32'h0, "credit spent");
            pulse(1'b1, 1'b1);
            pulse(1'b0, 1'b1);
            rd(LCP_REG_STAT, q);
            chk({16'h0, q[31:16]}, 32'h1, "shared count");
        end
    endtask

    task automatic t_plogi(input logic [31:0] ctl, input logic rnd, input logic [15:0] cnt);
        logic [31:0] q;
        @(posedge clk);
        cfgCredit <= 16'h0009;
        wr(LCP_REG_FEAT, rnd ? 32'h0001_0002 : 32'h0001_0001);
        wr(LCP_REG_W2, 32'h0003_005a);
        login(ctl | 32'h2);
        chk(32'(reqWasPlogi), 32'h1, "port login seen");
        rd(LCP_REG_STAT, q);
        chk({16'h0, q[31:16]}, {16'h0, cnt}, "port login credit use");
        chk({roContMask, roRandMask}, rnd ? 32'h0000_005a : 32'h005a_0000, "offset masks");
        rd(LCP_REG_PEERW2, q);
        chk(q, 32'h0003_00a5, "accept word 2 layout");
    endtask

    task automatic t_terr(input logic [31:0] c);
        logic [31:0] q;
        wr(LCP_REG_CREDIT, c);
        wr(LCP_REG_CTRL, 32'h1);
        rd(LCP_REG_STAT, q);
        chk({28'h0, q[3:0]}, 32'h8, "bad credit refused");
        wr(LCP_REG_STAT, 32'h8);
    endtask

    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata, frameSent, readyReturned} = '0;
        {cfgCredit, cfgAddrClean, cfgVf, cfgContOffset, cfgRandOffset} = {16'h0001, 4'h3};
        {cfgScN, cfgRxSize, cfgConcSeq, cfgRoMask} = {4'h3, 12'h800, 8'h03, 16'h00a5};
        {cfgRaTov, cfgEdTov} = {32'h0000_2710, 32'h0000_07d0};
        errTotal = 0;
        totalChecks = 0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_flogi(1'b1);
        t_flogi(1'b0);
        t_plogi(32'h0, 1'b0, 16'h0001);
        t_plogi(32'h8, 1'b1, 16'h0009);
        t_plogi(32'h14, 1'b0, 16'h0009);
        t_terr(32'h0);
        t_terr(32'h8000);
        stopTest();
    end
endmodule // lcp_tb_top
`default_nettype wire
